// [src/operand_decode_map.svh]
// offsets of instruction fields, extension figures and reset values
`ifndef OPERAND_DECODE_MAP_SVH
`define OPERAND_DECODE_MAP_SVH
`define OPC_HI 15
`define OPC_LO 12
`define RN_HI 11
`define RN_LO 8
`define RM_HI 7
`define RM_LO 4
`define DISP4_HI 3
`define DISP4_LO 0
`define IMM8_HI 7
`define IMM8_LO 0
`define TRAP_SHIFT 2
`define STEP_BYTE 3'h1
`define STEP_WORD 3'h2
`define STEP_LONG 3'h4
`define IMPLIED_REG 4'h0
`define NOP_WORD 16'h0009
`endif

// [src/operand_decode_pkg.sv]
// types shared by the operand field decoder
package operand_decode_pkg;
  // operand formats handled by the decoder
  typedef enum logic [3:0] {
    fmt_zero,
    fmt_reg_imm,
    fmt_imm_only,
    fmt_store_disp4,
    fmt_load_disp4,
    fmt_mac_word,
    fmt_src_only,
    fmt_dst_only,
    fmt_reg_reg
  } format_type;
  // how the immediate is widened
  typedef enum logic [1:0] {
    ext_zero,
    ext_sign,
    ext_trap
  } ext_mode_type;
  // pointer adjust around the access
  typedef enum logic [1:0] {
    adj_none,
    adj_post_inc,
    adj_pre_dec
  } adjust_type;
  // access size of a memory operand
  typedef enum logic [1:0] {
    size_byte,
    size_word,
    size_long
  } access_size_type;
  // implied operands besides general registers
  typedef enum logic [2:0] {
    imp_none,
    imp_index_reg,
    imp_global_base,
    imp_control_reg,
    imp_accum_pair
  } implied_type;
endpackage

// [src/immediate_extend.sv]
// widens an 8-bit immediate by zero, sign or trap-vector rule
module immediate_extend (
  // immediate and how to widen it
  input wire logic [7:0] imm_raw,
  input wire operand_decode_pkg::ext_mode_type mode,
  // 32-bit operand
  output logic [31:0] imm_ext
);
  import operand_decode_pkg::*;
  `include "operand_decode_map.svh"

  // pick extension; trap vector is a long-word index scaled to bytes
  always_comb begin
    case (mode)
      ext_zero: imm_ext = {24'h000000, imm_raw};
      ext_sign: imm_ext = {{24{imm_raw[7]}}, imm_raw};
      ext_trap: imm_ext = {22'h0, imm_raw, 2'h0};
      default: imm_ext = 32'h00000000;
    endcase
  end
endmodule

// [src/operand_field_decode.sv]
// operand field decoder for the 16-bit instruction word
module operand_field_decode (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fetched instruction and its decode class from the opcode decoder
  input wire logic insn_valid,
  input wire logic [15:0] insn_word,
  input wire operand_decode_pkg::format_type insn_format,
  input wire operand_decode_pkg::ext_mode_type imm_mode,
  input wire operand_decode_pkg::access_size_type mem_size,
  input wire logic from_memory,
  // operand selectors to the datapath
  output logic ops_valid,
  output operand_decode_pkg::format_type ops_format,
  output logic [3:0] src_reg,
  output logic src_reg_used,
  output logic [3:0] dst_reg,
  output logic dst_reg_used,
  output operand_decode_pkg::implied_type src_implied,
  output operand_decode_pkg::implied_type dst_implied,
  output logic [31:0] imm_value,
  output logic [3:0] disp_value,
  output operand_decode_pkg::adjust_type src_adjust,
  output operand_decode_pkg::adjust_type dst_adjust,
  output logic [2:0] adjust_step,
  output logic [15:0] opcode_bits
);
  import operand_decode_pkg::*;
  `include "operand_decode_map.svh"

  typedef struct packed {
    logic valid;
    format_type fmt;
    logic [3:0] src;
    logic src_used;
    logic [3:0] dst;
    logic dst_used;
    implied_type src_imp;
    implied_type dst_imp;
    logic [31:0] imm;
    logic [3:0] disp;
    adjust_type src_adj;
    adjust_type dst_adj;
    logic [2:0] step;
    logic [15:0] opc;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [31:0] imm_wide;
  logic [3:0] field_n;
  logic [3:0] field_m;
  logic [2:0] size_step;

  // raw fields; no remapping between field and register number
  assign field_n = insn_word[`RN_HI:`RN_LO];
  assign field_m = insn_word[`RM_HI:`RM_LO];

  // widening kept in its own module so trap scaling is shared
  immediate_extend u_ext (
    .imm_raw(insn_word[`IMM8_HI:`IMM8_LO]),
    .mode(imm_mode),
    .imm_ext(imm_wide)
  );

  // pointer step by access size
  always_comb begin
    case (mem_size)
      size_byte: size_step = `STEP_BYTE;
      size_word: size_step = `STEP_WORD;
      size_long: size_step = `STEP_LONG;
      default: size_step = `STEP_LONG;
    endcase
  end

  // next operand selection; invalid words leave a bubble, not stale ops
  always_comb begin
    state_d = '0;
    state_d.valid = insn_valid;
    state_d.fmt = insn_format;
    state_d.opc = insn_word;
    state_d.step = size_step;
    if (insn_valid) begin
      case (insn_format)
        fmt_reg_imm: begin
          state_d.dst = field_n;
          state_d.dst_used = 1'b1;
          state_d.src = field_n;
          state_d.src_used = 1'b1;
          state_d.imm = imm_wide;
        end
        fmt_imm_only: begin
          // trap, logic on index reg, or byte op at index+global base
          state_d.imm = imm_wide;
          if (imm_mode != ext_trap) begin
            state_d.src_imp = imp_index_reg;
            state_d.dst_imp = from_memory ? imp_global_base
                                          : imp_index_reg;
          end
        end
        fmt_store_disp4: begin
          state_d.src_imp = imp_index_reg;
          state_d.dst = field_m;
          state_d.dst_used = 1'b1;
          state_d.disp = insn_word[`DISP4_HI:`DISP4_LO];
        end
        fmt_load_disp4: begin
          state_d.src = field_m;
          state_d.src_used = 1'b1;
          state_d.disp = insn_word[`DISP4_HI:`DISP4_LO];
          state_d.dst_imp = imp_index_reg;
        end
        fmt_mac_word: begin
          // nnnn goes to the destination selector here, beside the accumulator pair
          state_d.src = field_m;
          state_d.src_used = 1'b1;
          state_d.dst = field_n;
          state_d.dst_used = 1'b1;
          state_d.src_adj = adj_post_inc;
          state_d.dst_adj = adj_post_inc;
          state_d.dst_imp = imp_accum_pair;
          state_d.step = `STEP_WORD;
        end
        fmt_src_only: begin
          state_d.src = field_n;
          state_d.src_used = 1'b1;
          state_d.src_adj = from_memory ? adj_post_inc : adj_none;
          state_d.dst_imp = imp_control_reg;
        end
        fmt_dst_only: begin
          state_d.src_imp = imp_control_reg;
          state_d.dst = field_n;
          state_d.dst_used = 1'b1;
          state_d.dst_adj = from_memory ? adj_pre_dec : adj_none;
        end
        fmt_reg_reg: begin
          state_d.src = field_m;
          state_d.src_used = 1'b1;
          state_d.dst = field_n;
          state_d.dst_used = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // one register stage, matching the pipeline decode slot
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign ops_valid = state_q.valid;
  assign ops_format = state_q.fmt;
  assign src_reg = state_q.src;
  assign src_reg_used = state_q.src_used;
  assign dst_reg = state_q.dst;
  assign dst_reg_used = state_q.dst_used;
  assign src_implied = state_q.src_imp;
  assign dst_implied = state_q.dst_imp;
  assign imm_value = state_q.imm;
  assign disp_value = state_q.disp;
  assign src_adjust = state_q.src_adj;
  assign dst_adjust = state_q.dst_adj;
  assign adjust_step = state_q.step;
  assign opcode_bits = state_q.opc;

  // checks on the registered operand selectors
  a_reg_imm_fields: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_reg_imm |=>
    dst_reg == $past(insn_word[11:8]) && dst_reg_used)
    else $error("reg-imm destination field wrong");
  a_imm_only_src: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_imm_only && imm_mode != ext_trap |=>
    src_implied == imp_index_reg && !src_reg_used)
    else $error("imm-only must use index register");
  a_store_disp: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_store_disp4 |=>
    dst_reg == $past(insn_word[7:4]) && disp_value == $past(insn_word[3:0])
    && src_implied == imp_index_reg)
    else $error("short store fields wrong");
  a_load_disp: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_load_disp4 |=>
    src_reg == $past(insn_word[7:4]) && dst_implied == imp_index_reg)
    else $error("short load fields wrong");
  a_mac_pointers: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_mac_word |=>
    src_adjust == adj_post_inc && dst_adjust == adj_post_inc
    && dst_implied == imp_accum_pair && adjust_step == 3'h2)
    else $error("mac pointers wrong");
  a_ctrl_load: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_src_only && from_memory |=>
    src_adjust == adj_post_inc && src_reg == $past(insn_word[11:8]))
    else $error("control load addressing wrong");
  a_ctrl_store: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_dst_only && from_memory |=>
    dst_adjust == adj_pre_dec && src_implied == imp_control_reg)
    else $error("control store addressing wrong");
  a_zero_extend: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_reg_imm && imm_mode == ext_zero |=>
    imm_value[31:8] == 24'h000000)
    else $error("zero extension wrong");
  a_sign_extend: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_reg_imm && imm_mode == ext_sign |=>
    imm_value == {{24{$past(insn_word[7])}}, $past(insn_word[7:0])})
    else $error("sign extension wrong");
  a_trap_scale: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_imm_only && imm_mode == ext_trap |=>
    imm_value == {22'h0, $past(insn_word[7:0]), 2'h0})
    else $error("trap offset wrong");
  a_step_size: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_src_only && mem_size == size_byte |=>
    adjust_step == 3'h1)
    else $error("byte step wrong");
  a_field_direct: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_format == fmt_reg_reg |=>
    src_reg == $past(insn_word[7:4]) && dst_reg == $past(insn_word[11:8]))
    else $error("register field remapped");

  c_mac: cover property (@(posedge clk) ops_valid
    && ops_format == fmt_mac_word);
  c_trap: cover property (@(posedge clk) ops_valid
    && ops_format == fmt_imm_only && imm_value[1:0] == 2'h0);
  c_ctrl_store: cover property (@(posedge clk) ops_valid
    && dst_adjust == adj_pre_dec);
endmodule

// [tb/insn_feed.sv]
// instruction feed model standing in for the fetch stage and opcode decoder
module insn_feed (
  // clock
  input wire logic clk,
  // instruction and its class toward the decoder
  output logic insn_valid,
  output logic [15:0] insn_word,
  output operand_decode_pkg::format_type insn_format,
  output operand_decode_pkg::ext_mode_type imm_mode,
  output operand_decode_pkg::access_size_type mem_size,
  output logic from_memory
);
  timeunit 1ns;
  timeprecision 100ps;
  import operand_decode_pkg::*;

  // quiet bus until the first instruction
  initial begin
    insn_valid = 1'b0;
    insn_word = 16'h0009;
    insn_format = fmt_zero;
    imm_mode = ext_zero;
    mem_size = size_byte;
    from_memory = 1'b0;
  end

  // caller stands just after a rising edge; held for one cycle
  task automatic present(input logic [15:0] w, input format_type f,
                         input ext_mode_type m, input access_size_type s,
                         input logic mem);
    insn_valid = 1'b1;
    insn_word = w;
    insn_format = f;
    imm_mode = m;
    mem_size = s;
    from_memory = mem;
  endtask

  // no instruction: the word flips so a stale value never looks valid
  task automatic idle();
    insn_valid = 1'b0;
    insn_word = ~insn_word;
    from_memory = ~from_memory;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the operand field decoder
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import operand_decode_pkg::*;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic insn_valid, from_memory, ops_valid, src_reg_used, dst_reg_used;
  logic [15:0] insn_word, opcode_bits;
  format_type insn_format, ops_format;
  ext_mode_type imm_mode;
  access_size_type mem_size;
  implied_type src_implied, dst_implied;
  adjust_type src_adjust, dst_adjust;
  logic [3:0] src_reg, dst_reg, disp_value;
  logic [31:0] imm_value;
  logic [2:0] adjust_step;
  int mismatches = 0;
  int samples_checked = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  insn_feed feed (.clk(clk), .insn_valid(insn_valid), .insn_word(insn_word),
    .insn_format(insn_format), .imm_mode(imm_mode), .mem_size(mem_size),
    .from_memory(from_memory));

  operand_field_decode DUT (.clk(clk), .reset(reset),
    .insn_valid(insn_valid), .insn_word(insn_word),
    .insn_format(insn_format), .imm_mode(imm_mode), .mem_size(mem_size),
    .from_memory(from_memory), .ops_valid(ops_valid),
    .ops_format(ops_format), .src_reg(src_reg),
    .src_reg_used(src_reg_used), .dst_reg(dst_reg),
    .dst_reg_used(dst_reg_used), .src_implied(src_implied),
    .dst_implied(dst_implied), .imm_value(imm_value),
    .disp_value(disp_value), .src_adjust(src_adjust),
    .dst_adjust(dst_adjust), .adjust_step(adjust_step),
    .opcode_bits(opcode_bits));

  // one compare for every result; an unknown counts as a mismatch
  task automatic cv(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one instruction in, answer sampled one edge later
  task automatic step(input logic [15:0] w, input format_type f,
                      input ext_mode_type m, input access_size_type s,
                      input logic mem);
    feed.present(w, f, m, s, mem);
    @(posedge clk);
    #1;
    cv(ops_valid, 1'b1);
    cv(ops_format, f);
    cv(opcode_bits, w);
  endtask

  // register-immediate in sign and zero widening modes
  task automatic s_reg_imm();
    step(16'h7a85, fmt_reg_imm, ext_sign, size_byte, 1'b0);
    cv(dst_reg, 4'ha);
    cv(dst_reg_used, 1'b1);
    cv(imm_value, 32'hffffff85);
    step(16'h717f, fmt_reg_imm, ext_sign, size_byte, 1'b0);
    cv(imm_value, 32'h0000007f);
    step(16'h72f0, fmt_reg_imm, ext_zero, size_byte, 1'b0);
    cv(imm_value, 32'h000000f0);
    cv(dst_reg, 4'h2);
  endtask

  // immediate-only: logic on index reg, global base byte op, trap
  task automatic s_imm_only();
    step(16'hc985, fmt_imm_only, ext_zero, size_byte, 1'b0);
    cv(imm_value, 32'h00000085);
    cv(dst_implied, imp_index_reg);
    cv(src_implied, imp_index_reg);
    step(16'hcd85, fmt_imm_only, ext_zero, size_byte, 1'b1);
    cv(dst_implied, imp_global_base);
    step(16'hc3ff, fmt_imm_only, ext_trap, size_byte, 1'b0);
    cv(imm_value, 32'h000003fc);
    cv(src_implied, imp_none);
  endtask

  // short displacement store and load
  task automatic s_disp4();
    step(16'h8057, fmt_store_disp4, ext_zero, size_byte, 1'b0);
    cv(src_implied, imp_index_reg);
    cv({dst_reg, disp_value}, 8'h57);
    cv({src_reg_used, dst_reg_used}, 2'h1);
    step(16'h856c, fmt_load_disp4, ext_zero, size_byte, 1'b0);
    cv({src_reg, disp_value}, 8'h6c);
    cv(dst_implied, imp_index_reg);
    cv({src_reg_used, dst_reg_used}, 2'h2);
  endtask

  task automatic s_mac();
    step(16'h4cbf, fmt_mac_word, ext_zero, size_word, 1'b0);
    cv({src_reg, dst_reg}, 8'hbc);
    cv({src_adjust, dst_adjust}, {adj_post_inc, adj_post_inc});
    cv(dst_implied, imp_accum_pair);
    cv(adjust_step, 3'h2);
  endtask

  task automatic s_control();
    step(16'h4e07, fmt_src_only, ext_zero, size_long, 1'b1);
    cv(src_reg, 4'he);
    cv(src_adjust, adj_post_inc);
    cv(dst_implied, imp_control_reg);
    cv(adjust_step, 3'h4);
    step(16'h4e0e, fmt_src_only, ext_zero, size_byte, 1'b1);
    cv(adjust_step, 3'h1);
    step(16'h4e0e, fmt_src_only, ext_zero, size_long, 1'b0);
    cv(src_adjust, adj_none);
    step(16'h4d03, fmt_dst_only, ext_zero, size_long, 1'b1);
    cv(dst_reg, 4'hd);
    cv(dst_adjust, adj_pre_dec);
    cv(src_implied, imp_control_reg);
    step(16'h4d02, fmt_dst_only, ext_zero, size_long, 1'b0);
    cv(dst_adjust, adj_none);
  endtask

  // every field value back to back, the two fields bitwise complemented
  task automatic s_fields();
    logic [3:0] n;
    for (int i = 0; i < 16; i++) begin
      n = 4'(i);
      step({4'h3, n, ~n, 4'hc}, fmt_reg_reg, ext_zero, size_long, 1'b0);
      cv({src_reg, dst_reg}, {~n, n});
    end
  endtask

  // reset in mid-run drops a pending instruction, then decode resumes
  task automatic s_reset();
    feed.present(16'h7a85, fmt_reg_imm, ext_sign, size_byte, 1'b0);
    reset = 1'b1;
    @(posedge clk);
    #1;
    cv(ops_valid, 1'b0);
    cv(imm_value, 32'h0);
    reset = 1'b0;
    step(16'h7b01, fmt_reg_imm, ext_sign, size_byte, 1'b0);
    cv(dst_reg, 4'hb);
  endtask

  // unknown format selects nothing; no instruction leaves a bubble
  task automatic s_idle();
    step(16'h0009, fmt_zero, ext_zero, size_byte, 1'b0);
    cv({src_reg_used, dst_reg_used, src_implied, dst_implied}, 8'h00);
    feed.idle();
    @(posedge clk);
    #1;
    cv(ops_valid, 1'b0);
    cv({src_reg_used, dst_reg_used}, 2'h0);
    cv(imm_value, 32'h0);
  endtask

  task automatic close_out();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 100 cycles
  initial begin
    #4000;
    mismatches++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    cv(ops_valid, 1'b0);
    cv(imm_value, 32'h0);
    s_reg_imm();
    s_imm_only();
    s_disp4();
    s_mac();
    s_control();
    s_fields();
    s_reset();
    s_idle();
    close_out();
  end
endmodule
